// ### hbridge_fault_sleep_control.sv
// Mode and protection sequencer of a brushed DC motor H-bridge driver.
// Assumes analog comparators deliver limit, thermal and supply flags
// asynchronously; the drive table is applied downstream of BRIDGE_EN.
//
// What this block and its host firmware do
// RULE_01: Sustained current limit beyond filter disables bridge
// RULE_02: Retry period elapses, bridge re-enables automatically
// RULE_03: Persistent overcurrent repeats filter, shutdown, retry
// RULE_04: Each high and low transistor watched separately
// RULE_05: Overcurrent path ignores regulation settings
// RULE_06: Over-temperature disables bridge, internals keep running
// RULE_07: Temperature clear resumes operation automatically
// RULE_08: Supply low disables everything, resets logic
// RULE_09: Lockout exit only on rising threshold flag
// RULE_10: Active needs supply good, input high, wake
// RULE_11: Either input high keeps bridge and internals on
// RULE_12: Both inputs low for sleep time enters sleep
// RULE_13: Sleep holds both outputs high impedance
// RULE_14: Power-up with inputs low sleeps immediately
// RULE_15: Host holds input high past wake time
// RULE_16: Any fault enters fault mode, bridge off
// RULE_17: Overcurrent or thermal recovery returns to active mode at once; lockout release goes through wake
// RULE_18: Host samples sense voltage for stall
// RULE_19: Host may ramp duty to limit inrush
// RULE_20: Interval timers restart when condition drops
`timescale 1ns/1ps
`include "hbridge_defines.svh"

module hbridge_fault_sleep_control (
   input  wire logic                   MCLK,
   input  wire logic                   RST,
   input  wire logic                   DRIVE_INPUT_A,
   input  wire logic                   DRIVE_INPUT_B,
   input  wire hbridge_pkg::fet_limit_t FET_LIMIT,
   input  wire logic                   THERMAL_HOT,
   input  wire logic                   SUPPLY_BELOW_FALL,
   input  wire logic                   SUPPLY_ABOVE_RISE,
   output logic                        BRIDGE_EN,
   output logic                        OUTPUTS_HIZ,
   output logic                        INTERNAL_EN,
   output logic                        FAULT_ACTIVE,
   output hbridge_pkg::gate_t          GATE_ALLOW,
   output hbridge_pkg::mode_t          MODE
);

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [1:0] in_a_s;
   logic [1:0] in_b_s;
   logic [3:0] lim_s0;
   logic [3:0] lim_s1;
   logic [1:0] hot_s;
   logic [1:0] fall_s;
   logic [1:0] rise_s;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         in_a_s <= 2'h0;
         in_b_s <= 2'h0;
         lim_s0 <= 4'h0;
         lim_s1 <= 4'h0;
         hot_s  <= 2'h0;
         fall_s <= 2'h3;
         rise_s <= 2'h0;
      end else begin
         in_a_s <= {in_a_s[0], DRIVE_INPUT_A};
         in_b_s <= {in_b_s[0], DRIVE_INPUT_B};
         lim_s0 <= FET_LIMIT;
         lim_s1 <= lim_s0;
         hot_s  <= {hot_s[0], THERMAL_HOT};
         fall_s <= {fall_s[0], SUPPLY_BELOW_FALL};
         rise_s <= {rise_s[0], SUPPLY_ABOVE_RISE};
      end
   end

   logic any_in_high;
   logic any_limit;
   assign any_in_high = in_a_s[1] | in_b_s[1];
   assign any_limit   = |lim_s1; // RULE_04 RULE_05

   ////////////////////////////////////////////////////////////////////////
   // Supply lockout with hysteresis

   logic lockout_q;
   logic lockout_d;

   always_comb begin
      lockout_d = lockout_q;
      if (fall_s[1]) begin
         lockout_d = 1'b1;
      end else if (rise_s[1]) begin
         lockout_d = 1'b0; // RULE_09
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         lockout_q <= 1'b1;
      end else begin
         lockout_q <= lockout_d;
      end
   end

   // Lockout acts as the internal logic reset
   logic lrst;
   assign lrst = RST | lockout_q; // RULE_08

   ////////////////////////////////////////////////////////////////////////
   // Interval timers

   function automatic logic [`CNT_W-1:0] tick(
      input logic              run,
      input logic [`CNT_W-1:0] cnt
   );
      if (!run) begin
         tick = '0;
      end else if (cnt == {`CNT_W{1'b1}}) begin
         tick = cnt;
      end else begin
         tick = cnt + `CNT_W'(1);
      end
   endfunction : tick

   localparam logic [`CNT_W-1:0] FILT_N  = `CNT_W'(`OCP_FILTER_CYC);
   localparam logic [`CNT_W-1:0] RETRY_N = `CNT_W'(`OCP_RETRY_CYC);
   localparam logic [`CNT_W-1:0] SLEEP_N = `CNT_W'(`SLEEP_ENTRY_CYC);
   localparam logic [`CNT_W-1:0] WAKE_N  = `CNT_W'(`WAKE_CYC);

   hbridge_pkg::mode_t mode_q;
   hbridge_pkg::mode_t mode_d;

   logic [`CNT_W-1:0] filt_q;
   logic [`CNT_W-1:0] retry_q;
   logic [`CNT_W-1:0] idle_q;
   logic [`CNT_W-1:0] wake_q;

   logic filt_run;
   logic retry_run;
   logic idle_run;
   logic wake_run;

   assign filt_run  = (mode_q == hbridge_pkg::MODE_ACTIVE) && any_limit;
   assign retry_run = (mode_q == hbridge_pkg::MODE_OCP_OFF);
   assign idle_run  = (mode_q == hbridge_pkg::MODE_ACTIVE) && !any_in_high;
   assign wake_run  = (mode_q == hbridge_pkg::MODE_WAKING) && any_in_high;

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         filt_q <= '0;
      end else begin
         filt_q <= tick(filt_run, filt_q); // RULE_20
      end
   end

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         retry_q <= '0;
      end else begin
         retry_q <= tick(retry_run, retry_q); // RULE_20
      end
   end

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         idle_q <= '0;
      end else begin
         idle_q <= tick(idle_run, idle_q); // RULE_20
      end
   end

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         wake_q <= '0;
      end else begin
         wake_q <= tick(wake_run, wake_q); // RULE_20
      end
   end

   logic filt_done;
   logic retry_done;
   logic idle_done;
   logic wake_done;
   assign filt_done  = filt_run && (filt_q >= FILT_N - `CNT_W'(1));
   assign retry_done = retry_run && (retry_q >= RETRY_N - `CNT_W'(1));
   assign idle_done  = idle_run && (idle_q >= SLEEP_N - `CNT_W'(1));
   assign wake_done  = wake_run && (wake_q >= WAKE_N - `CNT_W'(1));

   ////////////////////////////////////////////////////////////////////////
   // Mode sequencer

   // First cycle after lockout release decides immediate sleep
   logic fresh_q;

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         fresh_q <= 1'b1;
      end else begin
         fresh_q <= 1'b0;
      end
   end

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         hbridge_pkg::MODE_SLEEP: begin
            if (any_in_high) begin
               mode_d = hbridge_pkg::MODE_WAKING;
            end
         end
         hbridge_pkg::MODE_WAKING: begin
            if (fresh_q && !any_in_high) begin
               mode_d = hbridge_pkg::MODE_SLEEP; // RULE_14
            end else if (!any_in_high) begin
               mode_d = hbridge_pkg::MODE_SLEEP;
            end else if (wake_done) begin
               mode_d = hbridge_pkg::MODE_ACTIVE; // RULE_10 RULE_15
            end
         end
         hbridge_pkg::MODE_ACTIVE: begin
            if (hot_s[1]) begin
               mode_d = hbridge_pkg::MODE_THERMAL; // RULE_06 RULE_16
            end else if (filt_done) begin
               mode_d = hbridge_pkg::MODE_OCP_OFF; // RULE_01 RULE_16
            end else if (idle_done) begin
               mode_d = hbridge_pkg::MODE_SLEEP; // RULE_12
            end
         end
         hbridge_pkg::MODE_OCP_OFF: begin
            if (hot_s[1]) begin
               mode_d = hbridge_pkg::MODE_THERMAL;
            end else if (retry_done) begin
               mode_d = hbridge_pkg::MODE_ACTIVE; // RULE_02 RULE_03 RULE_17
            end
         end
         hbridge_pkg::MODE_THERMAL: begin
            if (!hot_s[1]) begin
               mode_d = hbridge_pkg::MODE_ACTIVE; // RULE_07 RULE_17
            end
         end
         default: begin
            mode_d = hbridge_pkg::MODE_SLEEP;
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         mode_q <= hbridge_pkg::MODE_WAKING;
      end else begin
         mode_q <= mode_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs

   function automatic logic is_fault(input hbridge_pkg::mode_t m);
      is_fault = (m == hbridge_pkg::MODE_OCP_OFF) ||
                 (m == hbridge_pkg::MODE_THERMAL);
   endfunction : is_fault

   logic               bridge_d;
   logic               hiz_d;
   logic               ien_d;
   logic               fault_d;
   hbridge_pkg::gate_t gate_d;
   hbridge_pkg::mode_t mode_out_d;

   always_comb begin
      bridge_d   = 1'b0;
      hiz_d      = 1'b1;
      ien_d      = 1'b0;
      fault_d    = 1'b0;
      gate_d     = '0;
      mode_out_d = hbridge_pkg::MODE_SLEEP;
      if (lockout_d) begin
         fault_d = 1'b1; // RULE_08
      end else begin
         bridge_d   = (mode_d == hbridge_pkg::MODE_ACTIVE); // RULE_11
         hiz_d      = !bridge_d; // RULE_13
         ien_d      = (mode_d != hbridge_pkg::MODE_SLEEP);
         fault_d    = is_fault(mode_d); // RULE_16
         gate_d     = {4{bridge_d}}; // RULE_01 RULE_06
         mode_out_d = mode_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         BRIDGE_EN <= 1'b0;
      end else begin
         BRIDGE_EN <= bridge_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         OUTPUTS_HIZ <= 1'b1;
      end else begin
         OUTPUTS_HIZ <= hiz_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         INTERNAL_EN <= 1'b0;
      end else begin
         INTERNAL_EN <= ien_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         FAULT_ACTIVE <= 1'b0;
      end else begin
         FAULT_ACTIVE <= fault_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         GATE_ALLOW <= '0;
      end else begin
         GATE_ALLOW <= gate_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         MODE <= hbridge_pkg::MODE_SLEEP;
      end else begin
         MODE <= mode_out_d;
      end
   end

endmodule : hbridge_fault_sleep_control

// ### hbridge_defines.svh
// Timing constants for the H-bridge mode and protection sequencer.
// Assumes a 50 MHz MCLK; times are in nanoseconds.
`ifndef HBRIDGE_DEFINES_SVH
`define HBRIDGE_DEFINES_SVH

`define CLK_PERIOD_NS      20
`define OCP_FILTER_NS      3000
`define OCP_RETRY_NS       100000
`define SLEEP_ENTRY_NS     120000
`define WAKE_NS            100000

`define OCP_FILTER_CYC  ((`OCP_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OCP_RETRY_CYC   ((`OCP_RETRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLEEP_ENTRY_CYC ((`SLEEP_ENTRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CYC        ((`WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define CNT_W           24

`endif

// ### hbridge_pkg.sv
// Types for the H-bridge mode and protection sequencer.
// Used with hbridge_defines.svh.
package hbridge_pkg;

   typedef enum logic [2:0] {
      MODE_SLEEP,
      MODE_WAKING,
      MODE_ACTIVE,
      MODE_OCP_OFF,
      MODE_THERMAL
   } mode_t;

   // Per-transistor current limit flags
   typedef struct packed {
      logic hs_a;
      logic ls_a;
      logic hs_b;
      logic ls_b;
   } fet_limit_t;

   // Bridge gate enables
   typedef struct packed {
      logic hs_a;
      logic ls_a;
      logic hs_b;
      logic ls_b;
   } gate_t;

endpackage : hbridge_pkg

// ### hbridge_fault_sleep_control_properties.sv
// Checker of the mode sequencer outputs.
// Sees only the top module ports; bound at the foot.
`timescale 1ns/1ps
module hbridge_fault_sleep_control_properties (
   input wire logic                    MCLK,
   input wire logic                    RST,
   input wire logic                    DRIVE_INPUT_A,
   input wire logic                    DRIVE_INPUT_B,
   input wire hbridge_pkg::fet_limit_t FET_LIMIT,
   input wire logic                    THERMAL_HOT,
   input wire logic                    SUPPLY_BELOW_FALL,
   input wire logic                    SUPPLY_ABOVE_RISE,
   input wire logic                    BRIDGE_EN,
   input wire logic                    OUTPUTS_HIZ,
   input wire logic                    INTERNAL_EN,
   input wire logic                    FAULT_ACTIVE,
   input wire hbridge_pkg::gate_t      GATE_ALLOW,
   input wire hbridge_pkg::mode_t      MODE
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   chk_hiz_inverse: assert property (OUTPUTS_HIZ == !BRIDGE_EN)
      else $error("hiz not inverse of bridge");
   chk_gate_follow: assert property (GATE_ALLOW == {4{BRIDGE_EN}})
      else $error("gates differ from bridge");
   chk_sleep_off: assert property (
      MODE == hbridge_pkg::MODE_SLEEP |-> !BRIDGE_EN && !INTERNAL_EN)
      else $error("sleep with circuits on");
   chk_active_on: assert property (
      MODE == hbridge_pkg::MODE_ACTIVE |->
      BRIDGE_EN && INTERNAL_EN && !FAULT_ACTIVE)
      else $error("active without bridge");
   chk_ocp_state: assert property (
      MODE == hbridge_pkg::MODE_OCP_OFF |->
      !BRIDGE_EN && INTERNAL_EN && FAULT_ACTIVE)
      else $error("overcurrent state wrong");
   chk_hot_enter: assert property (
      THERMAL_HOT [*4] |-> ##[0:1] MODE == hbridge_pkg::MODE_THERMAL
      && !BRIDGE_EN && INTERNAL_EN)
      else $error("thermal cutoff missed");
   chk_cool_resume: assert property (
      $fell(THERMAL_HOT) && MODE == hbridge_pkg::MODE_THERMAL |->
      ##[1:4] MODE == hbridge_pkg::MODE_ACTIVE)
      else $error("no resume after cooling");
   chk_lockout_off: assert property (
      SUPPLY_BELOW_FALL [*5] |-> !BRIDGE_EN && !INTERNAL_EN && FAULT_ACTIVE)
      else $error("lockout left circuits on");
endmodule : hbridge_fault_sleep_control_properties
bind hbridge_fault_sleep_control hbridge_fault_sleep_control_properties
   u_chk (.*);

// ### host_ctrl_model.sv
// Host microcontroller model driving the two control inputs.
// Commands come from the bench; levels change only after MCLK edges.
`timescale 1ns/1ps
module host_ctrl_model (
   input  wire logic MCLK,
   input  wire logic cmd_a,
   input  wire logic cmd_b,
   output logic      drv_a,
   output logic      drv_b
);
   // Whole-cycle levels keep wake holds exact
   // Duty ramping and sense sampling stay with firmware
   always_ff @(posedge MCLK) begin
      drv_a <= cmd_a;
      drv_b <= cmd_b;
   end
endmodule : host_ctrl_model

// ### hbridge_fault_sleep_control_tb_top.sv
// Self-checking bench of the H-bridge mode sequencer.
// Keeps the default timer values of the defines header.
`timescale 1ns/1ps
`include "hbridge_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   err_count++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module hbridge_fault_sleep_control_tb_top;
   localparam hbridge_pkg::mode_t SLP = hbridge_pkg::MODE_SLEEP;
   localparam hbridge_pkg::mode_t ACT = hbridge_pkg::MODE_ACTIVE;
   localparam hbridge_pkg::mode_t OVERCURRENT_GUARD = hbridge_pkg::MODE_OCP_OFF;
   localparam hbridge_pkg::mode_t HOT = hbridge_pkg::MODE_THERMAL;
   logic                    MCLK = 1'b0, RST = 1'b1, cmd_a = 1'b0;
   logic                    cmd_b = 1'b0, hot = 1'b0, below = 1'b0;
   logic                    above = 1'b0, in_a, in_b, en, hiz, ien, flt;
   hbridge_pkg::fet_limit_t lim = 4'h0;
   hbridge_pkg::gate_t      gate;
   hbridge_pkg::mode_t      mode;
   int                      err_count = 0, compares = 0, cyc = 0, n, b;
   localparam int           SLP_N = `SLEEP_ENTRY_CYC;
   always #10 MCLK = ~MCLK;
   host_ctrl_model u_host (.MCLK(MCLK), .cmd_a(cmd_a), .cmd_b(cmd_b),
      .drv_a(in_a), .drv_b(in_b));
   hbridge_fault_sleep_control u_dut (.MCLK(MCLK), .RST(RST),
      .DRIVE_INPUT_A(in_a), .DRIVE_INPUT_B(in_b), .FET_LIMIT(lim),
      .THERMAL_HOT(hot), .SUPPLY_BELOW_FALL(below),
      .SUPPLY_ABOVE_RISE(above), .BRIDGE_EN(en), .OUTPUTS_HIZ(hiz),
      .INTERNAL_EN(ien), .FAULT_ACTIVE(flt), .GATE_ALLOW(gate), .MODE(mode));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic in_win(input int v, input int lo, input int hi);
      return v >= lo && v <= hi;
   endfunction : in_win
   task automatic wait_mode(input hbridge_pkg::mode_t m, input int lim_c);
      n = 0;
      while (mode !== m && n < lim_c) begin
         @(negedge MCLK);
         n++;
      end
   endtask : wait_mode
   task automatic wrap_up();
      $display("counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h8584));
      repeat (12) @(posedge MCLK);
      RST <= 1'b0;
      repeat (8) @(negedge MCLK);
      `CHK("lockout", 1'b1, flt)
      @(posedge MCLK) above <= 1'b1;
      repeat (8) @(negedge MCLK);
      `CHK("power-up sleep", {SLP, 3'b010}, {mode, en, hiz, ien})
      $display("test power_up done");
      @(posedge MCLK) cmd_a <= 1'b1;
      repeat (20 + $urandom % 2000) @(posedge MCLK);
      cmd_a <= 1'b0;
      repeat (8) @(negedge MCLK);
      `CHK("short wake", SLP, mode)
      @(posedge MCLK) cmd_b <= 1'b1;
      wait_mode(ACT, `WAKE_CYC + 20);
      `CHK("wake time", 1'b1, in_win(n, `WAKE_CYC, `WAKE_CYC + 8))
      `CHK("active", 7'h7D, {gate, en, hiz, ien})
      $display("test wake done");
      for (b = 0; b < 4; b++) begin
         @(posedge MCLK) lim <= 4'h1 << b;
         repeat (10 + $urandom % 120) @(posedge MCLK);
         lim <= 4'h0;
         repeat (6) @(negedge MCLK);
         `CHK("limit glitch", ACT, mode)
         @(posedge MCLK) lim <= 4'h1 << b;
         wait_mode(OVERCURRENT_GUARD, 400);
         `CHK("filter", 1'b1, in_win(n, `OCP_FILTER_CYC, `OCP_FILTER_CYC + 6))
         @(posedge MCLK) lim <= 4'h0;
         hot <= 1'b1;
         wait_mode(HOT, 8);
         `CHK("thermal", {HOT, 3'b011}, {mode, en, ien, flt})
         @(posedge MCLK) hot <= 1'b0;
         wait_mode(ACT, 8);
         `CHK("resume", ACT, mode)
      end
      $display("test per_fet done");
      @(posedge MCLK) lim <= 4'h1 << ($urandom % 4);
      wait_mode(OVERCURRENT_GUARD, 400);
      wait_mode(ACT, `OCP_RETRY_CYC + 100);
      `CHK("retry", 1'b1, in_win(n, `OCP_RETRY_CYC - 2, `OCP_RETRY_CYC + 4))
      wait_mode(OVERCURRENT_GUARD, 400);
      `CHK("repeat", 1'b1, in_win(n, `OCP_FILTER_CYC - 4, `OCP_FILTER_CYC + 4))
      @(posedge MCLK) lim <= 4'h0;
      $display("test retry done");
      @(posedge MCLK) below <= 1'b1;
      above <= 1'b0;
      repeat (8) @(negedge MCLK);
      `CHK("lockout", 3'b001, {en, ien, flt})
      @(posedge MCLK) below <= 1'b0;
      repeat (8) @(negedge MCLK);
      `CHK("hysteresis", 1'b1, flt)
      @(posedge MCLK) above <= 1'b1;
      repeat (8) @(negedge MCLK);
      `CHK("wake again", 2'b00, {en, flt})
      $display("test lockout done");
      wait_mode(ACT, `WAKE_CYC + 20);
      `CHK("relock active", ACT, mode)
      @(posedge MCLK) cmd_b <= 1'b0;
      wait_mode(SLP, SLP_N + 20);
      `CHK("sleep entry", 1'b1, in_win(n, SLP_N, SLP_N + 8))
      `CHK("sleep off", 3'b010, {en, hiz, ien})
      $display("test sleep done");
      wrap_up();
   end
endmodule : hbridge_fault_sleep_control_tb_top
